// ### hw/cmk_regs_top.v
// Function
// - Thermal restart enabled only by control bit 0
// - Over-temperature with enable causes full digital reset
// - Thermal reset sets alert and prior-restart flag
// - Write-only command key; zero key only cancels a pending key one
// - Soft reset needs key one then key two
// - Load key updates all four DAC channels
// - Clear key loads clear value on enabled channels
// - Slewing channels ramp to clear value
// - Spare register stores value, no effect

`timescale 1ns/1ps
`include "cmk_regs.vh"
module cmk_regs_top #(
  parameter NCH = 4
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_resetn,
  // Register access from the serial frame decoder
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  output reg [15:0] o_rdata,
  // Over-temperature from the die sensor (asynchronous)
  input wire i_over_temp,
  // Channel setup from the output configuration registers
  input wire [NCH-1:0] i_clear_allow,
  input wire [NCH-1:0] i_slew_on,
  // Thermal restart status
  input wire i_flag_clear,
  output reg o_prior_restart_flag,
  output reg o_alert,
  // Reset and DAC actions
  output reg o_digital_reset,
  output reg o_dac_load_strobe,
  output reg [NCH-1:0] o_clear_step,
  output reg [NCH-1:0] o_clear_ramp
);
  // Stored registers
  reg [15:0] therm_ctrl_ff;
  reg [15:0] spare_ff;

  // Over-temperature sync and reset timing
  reg ot_s1_ff;
  reg ot_s2_ff;
  reg [2:0] rst_cnt_ff;
  reg therm_pend_ff;
  wire therm_fire;
  wire rst_start;
  wire rst_last;

  // Decoded commands and write strobes
  wire soft_rst;
  wire load_cmd;
  wire clear_cmd;
  wire wr_ctrl;
  wire wr_spare;
  wire wr_cmd;

  // Read multiplexer and channel index
  reg [15:0] nxt_rdata;
  genvar ch;

  // Address decode and reset triggers
  assign wr_ctrl = i_wr_en && (i_addr == `CMK_ADDR_THERM_CTRL);
  assign wr_spare = i_wr_en && (i_addr == `CMK_ADDR_SPARE);
  assign wr_cmd = i_wr_en && (i_addr == `CMK_ADDR_CMD);
  assign therm_fire = ot_s2_ff && therm_ctrl_ff[`CMK_THERM_EN_BIT];
  assign rst_start = (therm_fire || soft_rst) && !o_digital_reset;
  assign rst_last = o_digital_reset && (rst_cnt_ff == 3'h0);

  // Command key decoder
  cmk_key_decode u_dec (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_wr_any(i_wr_en),
    .i_wr_cmd(wr_cmd),
    .i_wdata(i_wdata),
    .o_soft_reset(soft_rst),
    .o_load(load_cmd),
    .o_clear(clear_cmd)
  );

  // Over-temperature synchroniser
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ot_s1_ff <= 1'b0;
      ot_s2_ff <= 1'b0;
    end
    else
    begin
      ot_s1_ff <= i_over_temp;
      ot_s2_ff <= ot_s1_ff;
    end
  end

  // Reset pulse stretcher
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_cnt_ff <= 3'h0;
      o_digital_reset <= 1'b0;
    end
    else if (rst_start)
    begin
      rst_cnt_ff <= `CMK_PULSE_CYCLES;
      o_digital_reset <= 1'b1;
    end
    else if (rst_cnt_ff != 3'h0)
      rst_cnt_ff <= rst_cnt_ff - 3'h1;
    else
      o_digital_reset <= 1'b0;
  end

  // Restart record, set beats clear
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      therm_pend_ff <= 1'b0;
      o_prior_restart_flag <= 1'b0;
      o_alert <= 1'b0;
    end
    else
    begin
      if (rst_start)
        therm_pend_ff <= therm_fire;
      else if (rst_last)
        therm_pend_ff <= 1'b0;
      if (rst_last && therm_pend_ff)
      begin
        o_prior_restart_flag <= 1'b1;
        o_alert <= 1'b1;
      end
      else if (i_flag_clear)
      begin
        o_prior_restart_flag <= 1'b0;
        o_alert <= 1'b0;
      end
    end
  end

  // Registers, cleared by a digital reset as well
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      therm_ctrl_ff <= `CMK_RST_THERM_CTRL;
      spare_ff <= `CMK_RST_SPARE;
    end
    else if (o_digital_reset)
    begin
      therm_ctrl_ff <= `CMK_RST_THERM_CTRL;
      spare_ff <= `CMK_RST_SPARE;
    end
    else
    begin
      if (wr_ctrl)
        therm_ctrl_ff <= {15'h0, i_wdata[`CMK_THERM_EN_BIT]};
      if (wr_spare)
        spare_ff <= i_wdata;
    end
  end

  // Register read selection
  always @*
  begin
    case (i_addr)
      `CMK_ADDR_THERM_CTRL: nxt_rdata = therm_ctrl_ff;
      `CMK_ADDR_SPARE: nxt_rdata = spare_ff;
      `CMK_ADDR_REV: nxt_rdata = {8'h00, `CMK_REV_CODE};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // Read data, held between reads
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_rdata <= 16'h0000;
    else if (i_rd_en)
      o_rdata <= nxt_rdata;
  end

  // Global DAC load strobe
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_dac_load_strobe <= 1'b0;
    else
      o_dac_load_strobe <= load_cmd;
  end

  // Per-channel clear strobes
  generate
    for (ch = 0; ch < NCH; ch = ch + 1)
    begin : g_clear
      always @(posedge i_sys_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          o_clear_step[ch] <= 1'b0;
          o_clear_ramp[ch] <= 1'b0;
        end
        else
        begin
          o_clear_step[ch] <= clear_cmd && i_clear_allow[ch] && !i_slew_on[ch];
          o_clear_ramp[ch] <= clear_cmd && i_clear_allow[ch] && i_slew_on[ch];
        end
      end
    end
  endgenerate

endmodule

// ### shared/cmk_regs.vh
`ifndef CMK_REGS_VH
`define CMK_REGS_VH
`define CMK_ADDR_THERM_CTRL 8'h43
`define CMK_ADDR_CMD 8'h44
`define CMK_ADDR_SPARE 8'h45
`define CMK_ADDR_REV 8'h46
`define CMK_THERM_EN_BIT 0
`define CMK_RST_THERM_CTRL 16'h0000
`define CMK_RST_SPARE 16'h0000
`define CMK_KEY_NOP 16'h0000
`define CMK_KEY_RESET1 16'h15fa
`define CMK_KEY_RESET2 16'haf51
`define CMK_KEY_LOAD 16'h953a
`define CMK_KEY_CLEAR 16'h73d1
`define CMK_REV_CODE 8'h5a
`define CMK_PULSE_CYCLES 3'h4
`endif

// ### hw/cmk_key_decode.v
`timescale 1ns/1ps
`include "cmk_regs.vh"
module cmk_key_decode (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_resetn,
  // Write events
  input wire i_wr_any,
  input wire i_wr_cmd,
  input wire [15:0] i_wdata,
  // Decoded commands
  output reg o_soft_reset,
  output reg o_load,
  output reg o_clear
);
  reg armed_ff;
  reg nxt_armed;
  always @*
  begin
    nxt_armed = armed_ff;
    if (i_wr_cmd)
      nxt_armed = (i_wdata == `CMK_KEY_RESET1);
    else if (i_wr_any)
      nxt_armed = 1'b0;
  end
  always @(posedge i_sys_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      armed_ff <= 1'b0;
      o_soft_reset <= 1'b0;
      o_load <= 1'b0;
      o_clear <= 1'b0;
    end
    else
    begin
      armed_ff <= nxt_armed;
      o_soft_reset <= i_wr_cmd && armed_ff && (i_wdata == `CMK_KEY_RESET2);
      o_load <= i_wr_cmd && (i_wdata == `CMK_KEY_LOAD);
      o_clear <= i_wr_cmd && (i_wdata == `CMK_KEY_CLEAR);
    end
  end
endmodule

// ### bench/cmk_regs_sva.sv
`timescale 1ns/1ps
module cmk_regs_sva #(
  parameter NCH = 4
) (
  // Watched ports
  input wire i_sys_clk,
  input wire i_resetn,
  input wire i_wr_en,
  input wire i_rd_en,
  input wire [7:0] i_addr,
  input wire [15:0] i_wdata,
  input wire [15:0] o_rdata,
  input wire [NCH-1:0] i_clear_allow,
  input wire [NCH-1:0] i_slew_on,
  input wire o_digital_reset,
  input wire o_dac_load_strobe,
  input wire [NCH-1:0] o_clear_step,
  input wire [NCH-1:0] o_clear_ramp
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  wire w = i_wr_en && i_addr == 8'h44;
  wire k1 = w && i_wdata == 16'h15fa;
  wire k2 = w && i_wdata == 16'haf51;
  a_load_key: assert property (w && i_wdata == 16'h953a |-> ##2 o_dac_load_strobe)
    else $error("load missing");
  a_load_once: assert property (o_dac_load_strobe |=> !o_dac_load_strobe)
    else $error("load too long");
  a_clear_step: assert property (w && i_wdata == 16'h73d1 |->
    ##2 o_clear_step == ($past(i_clear_allow) & ~$past(i_slew_on))) else $error("clear step");
  a_clear_ramp: assert property (w && i_wdata == 16'h73d1 |->
    ##2 o_clear_ramp == ($past(i_clear_allow) & $past(i_slew_on))) else $error("clear ramp");
  a_nop_quiet: assert property (w && i_wdata == 16'h0 |->
    ##2 !o_dac_load_strobe && o_clear_step == {NCH{1'b0}} &&
    o_clear_ramp == {NCH{1'b0}}) else $error("nop acted");
  a_soft_reset: assert property (k1 ##3 k2 |->
    ##2 o_digital_reset [*5] ##1 !o_digital_reset) else $error("soft reset");
  a_stray_key: assert property (k1 ##3 (i_wr_en && !w) ##3 k2 |->
    ##2 !o_digital_reset) else $error("stray reset");
  a_rev_ro: assert property (i_rd_en && i_addr == 8'h46 |=>
    o_rdata == 16'h005a) else $error("revision");
  cover property (o_digital_reset);
  cover property (o_clear_ramp != {NCH{1'b0}});
  cover property (o_dac_load_strobe);
endmodule
bind cmk_regs_top cmk_regs_sva #(.NCH(NCH)) u_sva (.*);

// ### bench/cmk_host.sv
`timescale 1ns/1ps
module cmk_host (
  // Register access
  input wire i_sys_clk,
  input wire [15:0] i_rdata,
  output reg o_wr_en = 1'h0,
  output reg o_rd_en = 1'h0,
  output reg [7:0] o_addr = 8'h0,
  output reg [15:0] o_wdata = 16'h0
);
  // One access per transaction, held for one cycle
  task acc(input w, input [7:0] a, input [15:0] d, output [15:0] q);
  begin
    @(posedge i_sys_clk);
    o_wr_en <= w;
    o_rd_en <= !w;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_sys_clk);
    o_wr_en <= 1'h0;
    o_rd_en <= 1'h0;
    o_wdata <= ~d;
    @(posedge i_sys_clk);
    q = i_rdata;
  end
  endtask
endmodule

// ### bench/cmk_regs_tb_top.sv
`timescale 1ns/1ps
module cmk_regs_tb_top;
  reg clk = 1'h0;
  reg rstn = 1'h0;
  reg ot = 1'h0;
  reg [15:0] q;
  reg [3:0] allow = 4'h5;
  reg [3:0] slew = 4'h3;
  reg fclr = 1'h0;
  wire wr, rd, flag, alert;
  wire [7:0] ad;
  wire [15:0] wd, rdat;
  integer err_total = 0;
  integer checks_done = 0;
  initial
  begin
    forever #2 clk = ~clk;
  end
  cmk_host h (.i_sys_clk(clk), .i_rdata(rdat), .o_wr_en(wr), .o_rd_en(rd), .o_addr(ad),
    .o_wdata(wd));
  cmk_regs_top DUT (.i_sys_clk(clk), .i_resetn(rstn), .i_wr_en(wr), .i_rd_en(rd),
    .i_addr(ad), .i_wdata(wd), .o_rdata(rdat), .i_over_temp(ot), .i_clear_allow(allow),
    .i_slew_on(slew), .i_flag_clear(fclr), .o_prior_restart_flag(flag), .o_alert(alert),
    .o_digital_reset(), .o_dac_load_strobe(), .o_clear_step(), .o_clear_ramp());
  task chk(input [15:0] g, input [15:0] e);
  begin
    checks_done = checks_done + 1;
    if (g !== e)
    begin
      err_total = err_total + 1;
      $display("CHECK FAILED %0t got %h", $time, g);
    end
  end
  endtask
  task w(input [7:0] a, input [15:0] d);
    h.acc(1'h1, a, d, q);
  endtask
  task rc(input [7:0] a, input [15:0] e);
  begin
    h.acc(1'h0, a, 16'h0, q);
    chk(q, e);
  end
  endtask
  task final_report;
  begin
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  initial
  begin
    #5000;
    err_total = err_total + 1;
    final_report;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'h1;
    rc(8'h43, 16'h0);
    w(8'h46, 16'hffff);
    rc(8'h46, 16'h005a);
    w(8'h44, 16'hffff);
    rc(8'h44, 16'h0);
    w(8'h45, 16'ha5c3);
    rc(8'h45, 16'ha5c3);
    w(8'h44, 16'h0);
    w(8'h44, 16'h953a);
    w(8'h44, 16'h73d1);
    allow <= 4'ha;
    slew <= 4'h6;
    w(8'h44, 16'h73d1);
    w(8'h44, 16'h15fa);
    w(8'h45, 16'h1234);
    w(8'h44, 16'haf51);
    rc(8'h45, 16'h1234);
    w(8'h44, 16'h15fa);
    w(8'h44, 16'haf51);
    repeat (8) @(posedge clk);
    rc(8'h45, 16'h0);
    $display("register tests done");
    ot <= 1'h1;
    repeat (20) @(posedge clk);
    chk({15'h0, flag}, 16'h0);
    ot <= 1'h0;
    w(8'h43, 16'hffff);
    rc(8'h43, 16'h1);
    ot <= 1'h1;
    repeat (20) @(posedge clk);
    chk({14'h0, alert, flag}, 16'h3);
    rc(8'h43, 16'h0);
    fclr <= 1'h1;
    @(posedge clk);
    fclr <= 1'h0;
    @(posedge clk);
    chk({14'h0, alert, flag}, 16'h0);
    $display("thermal tests done");
    final_report;
  end
endmodule
